// [rtl/snv_fifo.sv]
/*
  Small synchronous FIFO with valid and ready on both sides.
  Assumes one clock and a synchronous active-high reset; read data come from a register.
*/
module snv_fifo #(
  parameter int unsigned WIDTH = 26,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] fill;
  logic push;
  logic pop;

  // Honest full and empty from the pointer difference; out_data is a register.
  assign fill = wr_ptr - rd_ptr;
  assign in_ready = (fill != (AW + 1)'(DEPTH)) && !rst;
  assign push = in_valid && in_ready;
  assign pop = out_ready && (fill != '0) && (!out_valid || out_ready);

  // Storage writes.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Pointer and output register update; one word is kept in the output stage.
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        out_data <= mem[rd_ptr[AW-1:0]];
        rd_ptr <= rd_ptr + 1'b1;
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end

endmodule // snv_fifo

// [rtl/snv_front_end.sv]
/*
  SPI slave front end of a serial nonvolatile SRAM: chip-select framing, opcode capture,
  three-byte addressing, read and write data, recall control and power-down store setting.
  Assumes the SPI pins are asynchronous and much slower than REF_CLK, and that the array
  side answers read requests on MEM_RDATA some cycles after it takes them from the FIFO.
*/
module snv_front_end #(
  parameter int unsigned RECALL_CYCLES = snv_pkg::RECALL_CYCLES,
  parameter int unsigned POWER_UP_RECALL_CYCLES = snv_pkg::POWER_UP_RECALL_CYCLES,
  parameter int unsigned FIFO_DEPTH = 16
) (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST,
  // SPI pins; the output enable is low while SO is driven.
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SI,
  output logic SO,
  output logic SO_OE_N,
  // Supply monitor: high once the supply is above the switch threshold.
  input wire logic SUPPLY_GOOD,
  // Store-busy pin, open drain: low output enable pulls it low for busy.
  output logic STORE_BUSY_PIN,
  output logic STORE_BUSY_PIN_OE_N,
  // Array side: requests leave through the FIFO.
  output logic MEM_REQ_VALID,
  input wire logic MEM_REQ_READY,
  output snv_pkg::snv_req_t MEM_REQ,
  input wire logic MEM_RDATA_VALID,
  input wire logic [7:0] MEM_RDATA,
  // Recall control toward the array: clear phase, then copy phase.
  output logic RECALL_CLEAR,
  output logic RECALL_COPY,
  // Power-down store setting toward the store sequencer.
  output logic PD_STORE_ENABLE,
  // Mode found at the last select: 0 for mode 0, 1 for mode 3.
  output logic SPI_MODE3
);

  localparam int unsigned CW = $clog2(POWER_UP_RECALL_CYCLES + 1);

  // Returns 1 for an opcode that this front end knows.
  function automatic logic known_op(input logic [7:0] op);
    known_op = (op == snv_pkg::OP_READ) || (op == snv_pkg::OP_FAST_READ) ||
      (op == snv_pkg::OP_WRITE) || (op == snv_pkg::OP_RECALL) ||
      (op == snv_pkg::OP_PD_STORE_ENABLE) || (op == snv_pkg::OP_PD_STORE_DISABLE);
  endfunction

  // Returns 1 for an opcode that touches the memory array.
  function automatic logic mem_op(input logic [7:0] op);
    mem_op = (op == snv_pkg::OP_READ) || (op == snv_pkg::OP_FAST_READ) ||
      (op == snv_pkg::OP_WRITE);
  endfunction

  snv_pkg::snv_pins_t pins;
  logic supply_sync;
  logic sck_d;
  logic cs_n_d;
  logic supply_d;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic selected;
  snv_pkg::snv_state_t state;
  snv_pkg::snv_state_t next_state;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [2:0] bit_cnt;
  logic [1:0] byte_cnt;
  logic [7:0] opcode;
  logic [snv_pkg::ADDR_SENT-1:0] addr;
  logic byte_done;
  logic [7:0] rx_byte;
  logic recall_busy;
  logic [CW-1:0] recall_cnt;
  logic fall_pending;
  logic start_sw_recall;
  logic start_pu_recall;
  logic [7:0] tx_shift;
  logic [3:0] tx_left;
  logic read_req;
  logic write_req;
  logic fifo_in_valid;
  logic fifo_in_ready;
  snv_pkg::snv_req_t fifo_in;
  snv_pkg::snv_req_t fifo_out;
  logic fifo_out_valid;
  logic [snv_pkg::ADDR_USED-1:0] next_addr;

  // Pin synchronisers; deselected and idle levels at reset.
  snv_sync #(
    .WIDTH(4),
    .INIT(4'h8)
  ) u_sync (
    .clk(REF_CLK),
    .rst(RST),
    .async_in({CS_N, SCK, SI, SUPPLY_GOOD}),
    .sync_out({pins, supply_sync})
  );

  // Edge detection on synchronised levels only.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      sck_d <= 1'b0;
      cs_n_d <= 1'b1;
      supply_d <= 1'b0;
    end else begin
      sck_d <= pins.sck;
      cs_n_d <= pins.cs_n;
      supply_d <= supply_sync;
    end
  end

  assign selected = !pins.cs_n;
  assign cs_fall = cs_n_d && !pins.cs_n;
  assign sck_rise = selected && !sck_d && pins.sck;
  assign sck_fall = selected && sck_d && !pins.sck;

  // Shift register: MSB first, bits taken on rising edges only while selected.
  assign next_shift = {shift[6:0], pins.si};
  assign byte_done = sck_rise && (bit_cnt == 3'h7);
  assign rx_byte = next_shift;

  // Sequencer: first byte is the opcode, then three address bytes, a dummy byte for fast read, then data.
  always_comb begin
    next_state = state;
    if (!selected) begin
      next_state = snv_pkg::SNV_IDLE;
    end else begin
      case (state)
        snv_pkg::SNV_IDLE: begin
          if (cs_fall) begin
            next_state = snv_pkg::SNV_OPCODE;
          end
        end
        snv_pkg::SNV_OPCODE: begin
          if (byte_done) begin
            if (!known_op(rx_byte)) begin
              next_state = snv_pkg::SNV_IGNORE;
            end else if (mem_op(rx_byte) && !recall_busy) begin
              next_state = snv_pkg::SNV_ADDR;
            end else begin
              next_state = snv_pkg::SNV_IGNORE;
            end
          end
        end
        snv_pkg::SNV_ADDR: begin
          if (byte_done && byte_cnt == 2'(snv_pkg::ADDR_BYTES - 1)) begin
            next_state = (opcode == snv_pkg::OP_FAST_READ) ?
              snv_pkg::SNV_DUMMY : snv_pkg::SNV_DATA;
          end
        end
        snv_pkg::SNV_DUMMY: begin
          if (byte_done) begin
            next_state = snv_pkg::SNV_DATA;
          end
        end
        snv_pkg::SNV_DATA: begin
          if (recall_busy) begin
            next_state = snv_pkg::SNV_IGNORE;
          end
        end
        snv_pkg::SNV_IGNORE: next_state = snv_pkg::SNV_IGNORE;
        default: next_state = snv_pkg::SNV_IDLE;
      endcase
    end
  end

  // Bit, byte and field capture.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state <= snv_pkg::SNV_IDLE;
      shift <= 8'h00;
      bit_cnt <= 3'h0;
      byte_cnt <= 2'h0;
      opcode <= 8'h00;
      addr <= '0;
      SPI_MODE3 <= 1'b0;
    end else begin
      state <= next_state;
      if (cs_fall) begin
        bit_cnt <= 3'h0;
        byte_cnt <= 2'h0;
        SPI_MODE3 <= pins.sck;
      end else if (sck_rise) begin
        shift <= next_shift;
        bit_cnt <= bit_cnt + 3'h1;
        if (byte_done && state == snv_pkg::SNV_OPCODE) begin
          opcode <= rx_byte;
        end
        if (state == snv_pkg::SNV_ADDR) begin
          addr <= {addr[snv_pkg::ADDR_SENT-2:0], pins.si};
          if (byte_done) begin
            byte_cnt <= byte_cnt + 2'h1;
          end
        end else if (state == snv_pkg::SNV_DATA && byte_done) begin
          addr <= {7'h00, next_addr};
        end
      end
    end
  end

  // Only the low 17 bits address the array; burst rolls over at the top.
  assign next_addr = addr[snv_pkg::ADDR_USED-1:0] + 1'b1;
  assign read_req = (opcode == snv_pkg::OP_READ) || (opcode == snv_pkg::OP_FAST_READ);
  assign write_req = opcode == snv_pkg::OP_WRITE;

  // A read request is issued on entry to the data phase and after each byte sent.
  assign fifo_in_valid = !recall_busy && state == snv_pkg::SNV_DATA &&
    ((write_req && byte_done) ||
     (read_req && (next_state == snv_pkg::SNV_DATA) &&
      ((state != snv_pkg::SNV_DATA) || byte_done))) ||
    (read_req && !recall_busy && state != snv_pkg::SNV_DATA &&
     next_state == snv_pkg::SNV_DATA && selected);
  assign fifo_in.write = write_req;
  // Leaving the address phase, the last address bit is still on SI, not yet in addr.
  assign fifo_in.addr = (state == snv_pkg::SNV_ADDR) ?
    {addr[snv_pkg::ADDR_USED-2:0], pins.si} :
    (state == snv_pkg::SNV_DATA && byte_done && read_req) ?
    next_addr : addr[snv_pkg::ADDR_USED-1:0];
  assign fifo_in.data = rx_byte;

  // The FIFO decouples the link from the array; the array must keep up or words are lost.
  snv_fifo #(
    .WIDTH(snv_pkg::WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(REF_CLK),
    .rst(RST),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(MEM_REQ_READY),
    .out_data(fifo_out)
  );

  // Request outputs register the FIFO head, with valid masked by MEM_REQ_READY and recall_busy.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      MEM_REQ_VALID <= 1'b0;
      MEM_REQ <= '0;
    end else begin
      MEM_REQ_VALID <= fifo_out_valid && MEM_REQ_READY && !recall_busy;
      MEM_REQ <= fifo_out;
    end
  end

  // Serial output, MSB first on falling edges. A read byte often lands on the edge at which
  // SCK falls, so its top bit goes straight out; a fall with no byte waiting is remembered.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      tx_shift <= 8'h00;
      tx_left <= 4'h0;
      fall_pending <= 1'b0;
      SO <= 1'b0;
      SO_OE_N <= 1'b1;
    end else if (!selected || state != snv_pkg::SNV_DATA || !read_req) begin
      tx_left <= 4'h0;
      fall_pending <= 1'b0;
      SO_OE_N <= 1'b1;
    end else if (MEM_RDATA_VALID && tx_left == 4'h0 && (sck_fall || fall_pending)) begin
      SO <= MEM_RDATA[7];
      tx_shift <= {MEM_RDATA[6:0], 1'b0};
      tx_left <= 4'h7;
      fall_pending <= 1'b0;
      SO_OE_N <= 1'b0;
    end else if (MEM_RDATA_VALID && tx_left == 4'h0) begin
      tx_shift <= MEM_RDATA;
      tx_left <= 4'h8;
    end else if (sck_fall && tx_left != 4'h0) begin
      SO <= tx_shift[7];
      tx_shift <= {tx_shift[6:0], 1'b0};
      tx_left <= tx_left - 4'h1;
      SO_OE_N <= 1'b0;
    end else if (sck_fall) begin
      fall_pending <= 1'b1;
    end
  end

  // Recall starts: power-up on the supply rising, software on the recall opcode.
  assign start_pu_recall = supply_sync && !supply_d;
  assign start_sw_recall = byte_done && state == snv_pkg::SNV_OPCODE &&
    rx_byte == snv_pkg::OP_RECALL && !recall_busy;

  // Recall timer: one clear cycle, then copy until done; nonvolatile cells are never written.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      recall_busy <= 1'b0;
      recall_cnt <= '0;
      RECALL_CLEAR <= 1'b0;
      RECALL_COPY <= 1'b0;
    end else if (start_pu_recall) begin
      recall_busy <= 1'b1;
      recall_cnt <= CW'(POWER_UP_RECALL_CYCLES);
      RECALL_CLEAR <= 1'b1;
      RECALL_COPY <= 1'b0;
    end else if (start_sw_recall) begin
      recall_busy <= 1'b1;
      recall_cnt <= CW'(RECALL_CYCLES);
      RECALL_CLEAR <= 1'b1;
      RECALL_COPY <= 1'b0;
    end else if (recall_busy) begin
      recall_cnt <= recall_cnt - 1'b1;
      RECALL_CLEAR <= 1'b0;
      RECALL_COPY <= recall_cnt != CW'(1);
      recall_busy <= recall_cnt != CW'(1);
    end
  end

  // Store-busy pin pulled low while a recall runs, released otherwise.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      STORE_BUSY_PIN <= 1'b0;
      STORE_BUSY_PIN_OE_N <= 1'b1;
    end else begin
      STORE_BUSY_PIN <= 1'b0;
      STORE_BUSY_PIN_OE_N <= !(recall_busy || start_pu_recall || start_sw_recall);
    end
  end

  // Power-down store setting, volatile, enabled after reset.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      PD_STORE_ENABLE <= snv_pkg::PD_STORE_RESET;
    end else if (byte_done && state == snv_pkg::SNV_OPCODE) begin
      if (rx_byte == snv_pkg::OP_PD_STORE_DISABLE) begin
        PD_STORE_ENABLE <= 1'b0;
      end else if (rx_byte == snv_pkg::OP_PD_STORE_ENABLE) begin
        PD_STORE_ENABLE <= 1'b1;
      end
    end
  end

endmodule // snv_front_end

// [rtl/snv_pkg.sv]
/*
  Package of the serial nonvolatile SRAM front end: opcodes, address layout,
  recall timing, and the types that carry memory requests, pin levels and front-end state.
  Assumes a single 20 MHz reference clock shared by every file that uses it.
*/
package snv_pkg;

  // Reference clock rate in hertz.
  localparam int unsigned REF_CLK_HZ = 20_000_000;

  // Opcodes that this front end decodes.
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_RECALL = 8'h60;
  localparam logic [7:0] OP_PD_STORE_ENABLE = 8'h59;
  localparam logic [7:0] OP_PD_STORE_DISABLE = 8'h19;

  // Address layout: three bytes sent, low 17 bits used.
  localparam int unsigned ADDR_BYTES = 3;
  localparam int unsigned ADDR_USED = 17;
  localparam int unsigned ADDR_SENT = 8 * ADDR_BYTES;

  // Automatic power-down store is on as shipped.
  localparam logic PD_STORE_RESET = 1'b1;

  // Recall times in microseconds and their cycle counts (longest time, rounded down).
  localparam int unsigned RECALL_TIME_US = 600;
  localparam int unsigned POWER_UP_RECALL_TIME_US = 20000;
  localparam int unsigned RECALL_CYCLES = RECALL_TIME_US * (REF_CLK_HZ / 1_000_000);
  localparam int unsigned POWER_UP_RECALL_CYCLES =
    POWER_UP_RECALL_TIME_US * (REF_CLK_HZ / 1_000_000);

  // Data word handed to the array side through the FIFO.
  localparam int unsigned WORD_W = 1 + ADDR_USED + 8;

  // Front-end sequencer states, one-hot.
  typedef enum logic [5:0] {
    SNV_IDLE = 6'b000001,
    SNV_OPCODE = 6'b000010,
    SNV_ADDR = 6'b000100,
    SNV_DATA = 6'b001000,
    SNV_DUMMY = 6'b010000,
    SNV_IGNORE = 6'b100000
  } snv_state_t;

  // Memory request that crosses into the array side.
  typedef struct packed {
    logic write;
    logic [ADDR_USED-1:0] addr;
    logic [7:0] data;
  } snv_req_t;

  // Synchronised pin levels.
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } snv_pins_t;

endpackage : snv_pkg

// [rtl/snv_sync.sv]
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes the pins are asynchronous to clk; only the second stage is read outside.
*/
module snv_sync #(
  parameter int unsigned WIDTH = 3,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Raw and synchronised levels.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // The first stage feeds the second stage and nothing else.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= INIT;
      sync_out <= INIT;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule // snv_sync

// [test/snv_front_end_chk.sv]
/*
  Checker of the serial nonvolatile SRAM front end, watching only the top module's ports.
  Assumes the synchronous active-high reset and the one reference clock of the front end.
*/
module snv_front_end_chk #(
  parameter int unsigned RECALL_CYCLES = 20,
  parameter int unsigned POWER_UP_RECALL_CYCLES = 40
) (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST,
  // Watched ports.
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SUPPLY_GOOD,
  input wire logic SO_OE_N,
  input wire logic STORE_BUSY_PIN,
  input wire logic STORE_BUSY_PIN_OE_N,
  input wire logic MEM_REQ_VALID,
  input wire logic RECALL_CLEAR,
  input wire logic RECALL_COPY,
  input wire logic PD_STORE_ENABLE,
  input wire logic SPI_MODE3
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  localparam int PU_MAX = 8;
  logic [31:0] busy_cnt;

  // Length of the current busy stretch; cleared whenever the pin is released.
  always_ff @(posedge REF_CLK) begin
    busy_cnt <= (RST || STORE_BUSY_PIN_OE_N) ? 32'h0 : busy_cnt + 32'h1;
  end

  // Select held long enough for the synchronisers to have settled.
  sequence s_selected;
    $fell(CS_N) ##1 !CS_N [*7];
  endsequence
  sequence s_recall_start;
    $rose(RECALL_CLEAR);
  endsequence

  property p_reset_pd;
    disable iff (1'b0) RST |=> PD_STORE_ENABLE && SO_OE_N;
  endproperty
  a_reset_pd: assert property (p_reset_pd) else $error("reset values wrong");
  property p_float_deselected;
    CS_N [*8] |-> SO_OE_N;
  endproperty
  a_float_deselected: assert property (p_float_deselected) else $error("SO driven");
  property p_clear_then_copy;
    s_recall_start |=> !RECALL_CLEAR && RECALL_COPY;
  endproperty
  a_clear_then_copy: assert property (p_clear_then_copy) else $error("recall order");
  property p_busy_shown;
    (RECALL_CLEAR || RECALL_COPY) |-> !STORE_BUSY_PIN_OE_N && !STORE_BUSY_PIN;
  endproperty
  a_busy_shown: assert property (p_busy_shown) else $error("busy not shown");
  property p_no_access;
    RECALL_COPY |-> !MEM_REQ_VALID;
  endproperty
  a_no_access: assert property (p_no_access) else $error("access in recall");
  property p_busy_len;
    $rose(STORE_BUSY_PIN_OE_N) |-> busy_cnt inside {[RECALL_CYCLES-1:RECALL_CYCLES+1],
      [POWER_UP_RECALL_CYCLES-1:POWER_UP_RECALL_CYCLES+1]};
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("recall length wrong");
  property p_power_up;
    $rose(SUPPLY_GOOD) |-> ##[1:PU_MAX] RECALL_CLEAR;
  endproperty
  a_power_up: assert property (p_power_up) else $error("no power-up recall");
  property p_pd_in_frame;
    $changed(PD_STORE_ENABLE) |-> !CS_N;
  endproperty
  a_pd_in_frame: assert property (p_pd_in_frame) else $error("setting outside frame");
  property p_mode;
    s_selected |-> SPI_MODE3 == $past(SCK, 8);
  endproperty
  a_mode: assert property (p_mode) else $error("mode wrong");
endmodule // snv_front_end_chk

bind snv_front_end snv_front_end_chk #(
  .RECALL_CYCLES(RECALL_CYCLES),
  .POWER_UP_RECALL_CYCLES(POWER_UP_RECALL_CYCLES)
) i_snv_front_end_chk (
  .REF_CLK(REF_CLK), .RST(RST), .CS_N(CS_N), .SCK(SCK), .SUPPLY_GOOD(SUPPLY_GOOD),
  .SO_OE_N(SO_OE_N), .STORE_BUSY_PIN(STORE_BUSY_PIN),
  .STORE_BUSY_PIN_OE_N(STORE_BUSY_PIN_OE_N), .MEM_REQ_VALID(MEM_REQ_VALID),
  .RECALL_CLEAR(RECALL_CLEAR), .RECALL_COPY(RECALL_COPY),
  .PD_STORE_ENABLE(PD_STORE_ENABLE), .SPI_MODE3(SPI_MODE3)
);

// [test/snv_spi_master.sv]
/*
  Behavioural SPI bus master that frames instructions toward the front end.
  Assumes it is stepped by the reference clock; the serial clock is 400 ns a period.
*/
module snv_spi_master (
  // Reference clock.
  input wire logic clk,
  // SPI lines.
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  // Half a serial clock period; far below the fastest rate the link accepts.
  task automatic half();
    repeat (4) @(posedge clk);
  endtask

  // One framed instruction, sent from its top bit down; rx keeps the last eight bits read.
  // The clock moves outside frames only to the next mode's idle level, and SI flips when released, so nothing leans on it.
  task automatic frame(input logic mode3, input logic [63:0] tx, input int nbits,
                       output logic [7:0] rx);
    rx = 8'h00;
    sck <= mode3;
    half();
    cs_n <= 1'b0;
    half();
    if (mode3) begin
      sck <= 1'b0;
    end
    for (int i = nbits - 1; i >= 0; i--) begin
      si <= tx[i];
      half();
      sck <= 1'b1;
      half();
      rx = {rx[6:0], so};
      if (i > 0 || !mode3) begin
        sck <= 1'b0;
      end
    end
    half();
    cs_n <= 1'b1;
    si <= ~si;
    half();
  endtask
endmodule // snv_spi_master

// [test/testbench.sv]
/*
  Self-checking testbench of the serial nonvolatile SRAM front end.
  Assumes the checker is bound from its own file; the array side is modelled here.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned RC = 400;
  localparam int unsigned PUC = 600;
  logic REF_CLK, RST, CS_N, SCK, SI, SO, SO_OE_N, SUPPLY_GOOD, STORE_BUSY_PIN;
  logic STORE_BUSY_PIN_OE_N, MEM_REQ_VALID, MEM_REQ_READY, MEM_RDATA_VALID;
  logic RECALL_CLEAR, RECALL_COPY, PD_STORE_ENABLE, SPI_MODE3, so_alt, so_driven;
  logic [7:0] MEM_RDATA, rx;
  snv_pkg::snv_req_t MEM_REQ;
  snv_pkg::snv_req_t reqs[$];
  wire so_line = SO_OE_N ? so_alt : SO;
  int num_errors = 0;
  int n_compared = 0;
  int clr_cnt = 0;

  snv_front_end #(.RECALL_CYCLES(RC), .POWER_UP_RECALL_CYCLES(PUC)) i_snv_front_end (
    .REF_CLK(REF_CLK), .RST(RST), .CS_N(CS_N), .SCK(SCK), .SI(SI), .SO(SO),
    .SO_OE_N(SO_OE_N), .SUPPLY_GOOD(SUPPLY_GOOD), .STORE_BUSY_PIN(STORE_BUSY_PIN),
    .STORE_BUSY_PIN_OE_N(STORE_BUSY_PIN_OE_N), .MEM_REQ_VALID(MEM_REQ_VALID),
    .MEM_REQ_READY(MEM_REQ_READY), .MEM_REQ(MEM_REQ), .MEM_RDATA_VALID(MEM_RDATA_VALID),
    .MEM_RDATA(MEM_RDATA), .RECALL_CLEAR(RECALL_CLEAR), .RECALL_COPY(RECALL_COPY),
    .PD_STORE_ENABLE(PD_STORE_ENABLE), .SPI_MODE3(SPI_MODE3));
  snv_spi_master i_snv_spi_master (.clk(REF_CLK), .cs_n(CS_N), .sck(SCK), .si(SI),
    .so(so_line));

  initial begin
    REF_CLK = 1'b0;
    forever #25 REF_CLK = ~REF_CLK;
  end

  // Array model: takes requests, answers reads one cycle later; released SO toggles.
  always @(posedge REF_CLK) begin
    so_alt <= ~so_alt;
    MEM_RDATA_VALID <= 1'b0;
    if (RECALL_CLEAR === 1'b1) clr_cnt++;
    if (SO_OE_N === 1'b0) so_driven = 1'b1;
    if (MEM_REQ_VALID === 1'b1 && MEM_REQ_READY === 1'b1) begin
      reqs.push_back(MEM_REQ);
      if (MEM_REQ.write === 1'b0) begin
        MEM_RDATA_VALID <= 1'b1;
        MEM_RDATA <= 8'h3c;
      end
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Length of the next busy stretch on the store-busy pin, bounded on both waits.
  task automatic busy_len(output int n);
    int k;
    n = 0;
    for (k = 0; k < 2000 && STORE_BUSY_PIN_OE_N !== 1'b0; k++) @(posedge REF_CLK);
    for (k = 0; k < 2000 && STORE_BUSY_PIN_OE_N === 1'b0; k++) @(posedge REF_CLK);
    n = k;
    if (k == 2000) begin
      num_errors++;
      finish_test();
    end
  endtask

  task automatic t_power_up();
    int n;
    check("reset pd", PD_STORE_ENABLE, 1'b1);
    check("reset so_oe_n", SO_OE_N, 1'b1);
    SUPPLY_GOOD <= 1'b1;
    busy_len(n);
    check("power-up busy", n >= PUC - 1 && n <= PUC + 1, 1'b1);
    check("power-up clear", clr_cnt, 1);
  endtask

  task automatic t_pd_setting();
    i_snv_spi_master.frame(1'b0, 64'h19, 8, rx);
    check("pd disable", PD_STORE_ENABLE, 1'b0);
    check("mode 0", SPI_MODE3, 1'b0);
    i_snv_spi_master.frame(1'b0, 64'h59, 8, rx);
    check("pd enable", PD_STORE_ENABLE, 1'b1);
  endtask

  // Burst write while the array stalls: upper seven address bits are ones and ignored.
  task automatic t_write_burst();
    reqs.delete();
    MEM_REQ_READY <= 1'b0;
    i_snv_spi_master.frame(1'b0, 64'h02_ff2345_a55a0f, 56, rx);
    check("held while stalled", reqs.size(), 0);
    MEM_REQ_READY <= 1'b1;
    repeat (10) @(posedge REF_CLK);
    check("burst count", reqs.size(), 3);
    if (reqs.size() == 3) begin
      check("addr 0", reqs[0].addr, 17'h12345);
      check("data 0", reqs[0].data, 8'ha5);
      check("write 0", reqs[0].write, 1'b1);
      check("addr 2", reqs[2].addr, 17'h12347);
      check("data 2", reqs[2].data, 8'h0f);
    end
  endtask

  task automatic t_read();
    reqs.delete();
    i_snv_spi_master.frame(1'b0, 64'h03_000010_00, 40, rx);
    check("read data", rx, 8'h3c);
    check("read req", reqs.size() >= 1, 1'b1);
    if (reqs.size() >= 1) check("read addr", reqs[0].addr, 17'h00010);
  endtask

  task automatic t_mode3();
    reqs.delete();
    i_snv_spi_master.frame(1'b1, 64'h02_000100_c3, 40, rx);
    repeat (10) @(posedge REF_CLK);
    check("mode 3", SPI_MODE3, 1'b1);
    check("mode 3 count", reqs.size(), 1);
    if (reqs.size() == 1) check("mode 3 data", reqs[0].data, 8'hc3);
  endtask

  // Unknown opcode followed by a well-formed write: nothing may happen.
  task automatic t_invalid();
    reqs.delete();
    so_driven = 1'b0;
    i_snv_spi_master.frame(1'b0, 64'h1e_02_ff2345_a5, 48, rx);
    repeat (10) @(posedge REF_CLK);
    check("invalid count", reqs.size(), 0);
    check("invalid so", so_driven, 1'b0);
  endtask

  // Write sent early during a software recall is dropped; one sent after it lands.
  task automatic t_sw_recall();
    int n;
    reqs.delete();
    clr_cnt = 0;
    i_snv_spi_master.frame(1'b0, 64'h60, 8, rx);
    check("recall busy", STORE_BUSY_PIN_OE_N, 1'b0);
    i_snv_spi_master.frame(1'b0, 64'h02_000020_77, 40, rx);
    check("blocked write", reqs.size(), 0);
    n = 0;
    busy_len(n);
    check("recall clear", clr_cnt, 1);
    i_snv_spi_master.frame(1'b0, 64'h02_000020_77, 40, rx);
    repeat (10) @(posedge REF_CLK);
    check("write after", reqs.size(), 1);
  endtask

  // Main sequence.
  initial begin
    RST = 1'b1;
    SUPPLY_GOOD = 1'b0;
    MEM_REQ_READY = 1'b1;
    MEM_RDATA_VALID = 1'b0;
    MEM_RDATA = 8'h00;
    so_alt = 1'b0;
    so_driven = 1'b0;
    repeat (2) @(posedge REF_CLK);
    RST <= 1'b0;
    repeat (4) @(posedge REF_CLK);
    t_power_up();
    t_pd_setting();
    t_write_burst();
    t_read();
    t_mode3();
    t_invalid();
    t_sw_recall();
    finish_test();
  end
endmodule // testbench
